/* File: include/tcs_pkg.sv */
// tcs_pkg: register map, field positions, reset values and codes of the timer setup block
package tcs_pkg;
  // ********
  // register map, byte addresses
  // ********
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFF_PORT_DIR  = 8'h00;
  localparam logic [7:0]  OFF_PORT_DATA = 8'h04;
  localparam logic [7:0]  OFF_CLK_GATE  = 8'h08;
  localparam logic [7:0]  OFF_PRI_LSB_L = 8'h0C;
  localparam logic [7:0]  OFF_PRI_MSB_L = 8'h10;
  localparam logic [7:0]  OFF_PRI_LSB_H = 8'h14;
  localparam logic [7:0]  OFF_PRI_MSB_H = 8'h18;
  localparam logic [7:0]  OFF_START     = 8'h1C;
  localparam logic [7:0]  OFF_STOP      = 8'h20;
  localparam logic [7:0]  OFF_PRESCALE  = 8'h24;
  localparam logic [7:0]  OFF_MODE_CH0  = 8'h28;
  localparam logic [7:0]  OFF_MODE_CH1  = 8'h2C;
  localparam logic [7:0]  OFF_STATUS    = 8'h30;
  localparam logic [7:0]  OFF_IRQ_PEND  = 8'h34;
  localparam logic [7:0]  OFF_CAPT_CH0  = 8'h38;
  localparam logic [7:0]  OFF_CAPT_CH1  = 8'h3C;
  // ********
  // field positions
  // ********
  localparam int          INPUT_B_DIR_BIT = 4;
  localparam int          CLOCK_ON_BIT    = 0;
  localparam int          PRI_LOW_BIT     = 7;
  localparam int          PRI_HIGH_BIT    = 0;
  localparam int          OP_CHOICE_BIT   = 7;
  localparam int          COUNT_SRC_BIT   = 4;
  localparam int          SPLIT_BIT       = 3;
  localparam int          PRS_ONE_LSB     = 4;
  // ********
  // reset values
  // ********
  localparam logic [7:0]  RST_PORT_DIR  = 8'hFF;
  localparam logic [7:0]  RST_PORT_DATA = 8'h00;
  localparam logic [7:0]  RST_CLK_GATE  = 8'h00;
  localparam logic [7:0]  RST_PRI       = 8'hFF;
  localparam logic [7:0]  RST_PRESCALE  = 8'h00;
  localparam logic [7:0]  RST_MODE      = 8'h00;
  localparam logic [15:0] RST_CAPT      = 16'h0000;
  // ********
  // bus answers and trigger source codes
  // ********
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  typedef enum logic [2:0] {
    TCS_TRIG_SW       = 3'b000,
    TCS_TRIG_EDGE     = 3'b001,
    TCS_TRIG_BOTH     = 3'b010,
    TCS_TRIG_MASTER   = 3'b100,
    TCS_TRIG_MASTER_E = 3'b110
  } tcs_trig_t;
endpackage

/* File: include/tcs_chan_if.sv */
// tcs_chan_if: signals between the register core and one timer channel
`timescale 1ns/1ps
interface tcs_chan_if;
  logic [7:0]  mode_high;
  logic        unit_on;
  logic        tick_zero;
  logic        tick_one;
  logic        pin_rise;
  logic        pin_fall;
  logic        master_irq;
  logic        sw_start;
  logic        sw_stop;
  logic        run_flag;
  logic        irq;
  logic [15:0] capture;
  modport ctrl (output mode_high, unit_on, tick_zero, tick_one, pin_rise, pin_fall, master_irq,
                output sw_start, sw_stop, input run_flag, irq, capture);
  modport chan (input mode_high, unit_on, tick_zero, tick_one, pin_rise, pin_fall, master_irq,
                input sw_start, sw_stop, output run_flag, irq, capture);
endinterface

/* File: logic/tcs_channel.sv */
// tcs_channel: one timer channel, clock choice, trigger source and a capture counter
`timescale 1ns/1ps
module tcs_channel #(
  parameter bit HAS_SPLIT = 1'b0
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // channel link
  tcs_chan_if.chan  ch
);
  logic        counting_reg;
  logic [15:0] count_reg;
  logic        op_tick;
  logic        count_tick;
  logic        hw_start;
  logic        capt;
  logic        stop_after;
  logic [2:0]  trig;

  assign trig       = ch.mode_high[2:0];
  assign op_tick    = ch.mode_high[tcs_pkg::OP_CHOICE_BIT] ? ch.tick_one : ch.tick_zero;
  assign count_tick = ch.mode_high[tcs_pkg::COUNT_SRC_BIT] ? ch.pin_rise : op_tick;

  // ********
  // trigger decode
  // ********
  always_comb begin
    hw_start   = 1'b0;
    capt       = 1'b0;
    stop_after = 1'b0;
    case (trig)
      tcs_pkg::TCS_TRIG_SW: begin
        hw_start = 1'b0;
      end
      tcs_pkg::TCS_TRIG_EDGE: begin
        hw_start = ch.pin_rise;
        capt     = ch.pin_rise && counting_reg;
      end
      tcs_pkg::TCS_TRIG_BOTH: begin
        hw_start   = ch.pin_rise;
        capt       = ch.pin_fall && counting_reg;
        stop_after = 1'b1;
      end
      tcs_pkg::TCS_TRIG_MASTER: begin
        hw_start = ch.master_irq;
      end
      tcs_pkg::TCS_TRIG_MASTER_E: begin
        hw_start   = ch.master_irq;
        capt       = ch.pin_rise && counting_reg;
        stop_after = 1'b1;
      end
      default: begin
        hw_start = 1'b0;
      end
    endcase
  end

  // ********
  // run flag
  // ********
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ch.run_flag <= 1'b0;
    end else if (ch.sw_stop) begin
      ch.run_flag <= 1'b0;
    end else if (ch.sw_start) begin
      ch.run_flag <= 1'b1;
    end
  end

  // ********
  // counter, capture and interrupt pulse
  // ********
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      counting_reg <= 1'b0;
      count_reg    <= 16'h0000;
      ch.capture   <= tcs_pkg::RST_CAPT;
      ch.irq       <= 1'b0;
    end else begin
      ch.irq <= 1'b0;
      if (ch.sw_stop || !ch.run_flag) begin
        counting_reg <= 1'b0;
      end else if (ch.unit_on) begin
        if (capt) begin
          ch.capture <= count_reg;
          ch.irq     <= 1'b1;
          count_reg  <= 16'h0000;
          if (stop_after) begin
            counting_reg <= 1'b0;
          end
        end else if (hw_start || (ch.sw_start && trig == tcs_pkg::TCS_TRIG_SW)) begin
          counting_reg <= 1'b1;
          count_reg    <= 16'h0000;
        end else if (counting_reg && count_tick) begin
          if (HAS_SPLIT && ch.mode_high[tcs_pkg::SPLIT_BIT]) begin
            count_reg <= {8'h00, count_reg[7:0] + 8'h01};
          end else begin
            count_reg <= count_reg + 16'h0001;
          end
        end
      end
    end
  end
endmodule

/* File: logic/tcs_timer_setup.sv */
// tcs_timer_setup: register core of the two-channel timer setup block with AXI4-Lite slave
// Function
// - direction bit 4: 0 drives input B pin as output, 1 leaves it input.
// - clock gate bit 0: 0 stops timer unit clock, 1 supplies it.
// - two-bit channel priority, one bit per flag register; 00 highest, 11 lowest.
// - writing 1 to stop trigger clears run flag and halts counting; 0 ignored.
// - prescale code 0..15 makes op clock zero the clock divided by 2^code.
// - mode bit 7 picks op clock zero (0) or op clock one (1).
// - mode bit 4 counts op clock (0) or valid input pin edges (1).
// - channel 1 mode bit 3: 0 one 16-bit timer, 1 one 8-bit timer in the low byte, high byte held at 0.
// - trigger code 000: only software start trigger starts the channel; counting begins only on a start write while the run flag is already set.
// - trigger code 001: input pin valid edge is start and capture trigger.
// - trigger code 010: one pin edge starts, the other edge captures.
// - trigger code 100: slave channel starts on master channel interrupt.
// - trigger code 110: start on master interrupt, end on own pin edge.
// - writing 1 to start trigger sets run flag enabling counting; 0 ignored.
// - channel interrupt sets sticky pending flag until software clears it.
`timescale 1ns/1ps
module tcs_timer_setup (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid_i,
  output wire logic        s_axi_awready_o,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic [2:0]  s_axi_awprot_i,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid_i,
  output wire logic        s_axi_wready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  // axi4-lite write response
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  output logic      [1:0]  s_axi_bresp_o,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid_i,
  output wire logic        s_axi_arready_o,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic [2:0]  s_axi_arprot_i,
  // axi4-lite read data
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic      [31:0] s_axi_rdata_o,
  output logic      [1:0]  s_axi_rresp_o,
  // timer input pins
  input  wire logic        timer_input_pin_i,
  input  wire logic        input_b_i,
  output logic             input_b_o,
  output logic             input_b_oe_o,
  // channel interrupts and priorities
  output wire logic [1:0]  channel_irq_o,
  output wire logic [1:0]  ch0_priority_o,
  output wire logic [1:0]  ch1_priority_o
);
  // ********
  // registers
  // ********
  logic [7:0]  port_dir_reg;
  logic [7:0]  port_data_reg;
  logic [7:0]  clk_gate_reg;
  logic [7:0]  pri_lsb_l_reg;
  logic [7:0]  pri_msb_l_reg;
  logic [7:0]  pri_lsb_h_reg;
  logic [7:0]  pri_msb_h_reg;
  logic [7:0]  prescale_reg;
  logic [7:0]  mode_reg [2];
  logic [1:0]  irq_pend_reg;
  logic [1:0]  irq_pend_next;
  logic [14:0] pre_cnt_reg;
  logic [1:0]  pin_prev_reg;
  logic [1:0]  pin_now;
  logic        aw_held_reg;
  logic [7:0]  aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire;
  logic        wr_lane;
  logic        wr_hit;
  logic [7:0]  wbyte;
  logic        unit_on;
  logic        tick_zero;
  logic        tick_one;
  logic [1:0]  sw_start;
  logic [1:0]  sw_stop;
  logic [1:0]  irq_pulse;
  logic [1:0]  run_flags;
  logic [15:0] capt [2];
  logic [31:0] rd_data;
  logic        rd_hit;

  tcs_chan_if chan_link [2] ();

  // ********
  // axi4-lite write channel
  // ********
  assign s_axi_awready_o = !aw_held_reg && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_held_reg && !s_axi_bvalid_o;
  assign wr_fire         = aw_held_reg && w_held_reg && !s_axi_bvalid_o;
  assign wr_lane         = wr_fire && w_strb_reg[0];
  assign wbyte           = w_data_reg[7:0];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr_i;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata_i;
      w_strb_reg <= s_axi_wstrb_i;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_comb begin
    case ({aw_addr_reg[7:2], 2'b00})
      tcs_pkg::OFF_PORT_DIR, tcs_pkg::OFF_PORT_DATA, tcs_pkg::OFF_CLK_GATE,
      tcs_pkg::OFF_PRI_LSB_L, tcs_pkg::OFF_PRI_MSB_L, tcs_pkg::OFF_PRI_LSB_H,
      tcs_pkg::OFF_PRI_MSB_H, tcs_pkg::OFF_START, tcs_pkg::OFF_STOP,
      tcs_pkg::OFF_PRESCALE, tcs_pkg::OFF_MODE_CH0, tcs_pkg::OFF_MODE_CH1,
      tcs_pkg::OFF_STATUS, tcs_pkg::OFF_IRQ_PEND, tcs_pkg::OFF_CAPT_CH0,
      tcs_pkg::OFF_CAPT_CH1: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= tcs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_hit ? tcs_pkg::RESP_OKAY : tcs_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ********
  // configuration registers
  // ********
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      port_dir_reg  <= tcs_pkg::RST_PORT_DIR;
      port_data_reg <= tcs_pkg::RST_PORT_DATA;
      clk_gate_reg  <= tcs_pkg::RST_CLK_GATE;
      pri_lsb_l_reg <= tcs_pkg::RST_PRI;
      pri_msb_l_reg <= tcs_pkg::RST_PRI;
      pri_lsb_h_reg <= tcs_pkg::RST_PRI;
      pri_msb_h_reg <= tcs_pkg::RST_PRI;
      prescale_reg  <= tcs_pkg::RST_PRESCALE;
      mode_reg[0]   <= tcs_pkg::RST_MODE;
      mode_reg[1]   <= tcs_pkg::RST_MODE;
    end else if (wr_lane) begin
      case ({aw_addr_reg[7:2], 2'b00})
        tcs_pkg::OFF_PORT_DIR:  port_dir_reg  <= wbyte;
        tcs_pkg::OFF_PORT_DATA: port_data_reg <= wbyte;
        tcs_pkg::OFF_CLK_GATE:  clk_gate_reg  <= wbyte;
        tcs_pkg::OFF_PRI_LSB_L: pri_lsb_l_reg <= wbyte;
        tcs_pkg::OFF_PRI_MSB_L: pri_msb_l_reg <= wbyte;
        tcs_pkg::OFF_PRI_LSB_H: pri_lsb_h_reg <= wbyte;
        tcs_pkg::OFF_PRI_MSB_H: pri_msb_h_reg <= wbyte;
        tcs_pkg::OFF_PRESCALE:  prescale_reg  <= wbyte;
        tcs_pkg::OFF_MODE_CH0:  mode_reg[0]   <= {wbyte[7:4], 1'b0, wbyte[2:0]};
        tcs_pkg::OFF_MODE_CH1:  mode_reg[1]   <= wbyte;
        default: begin
        end
      endcase
    end
  end

  // start and stop triggers are one-cycle strobes, zero bits do nothing
  assign sw_start = (wr_lane && {aw_addr_reg[7:2], 2'b00} == tcs_pkg::OFF_START) ? wbyte[1:0] : 2'b00;
  assign sw_stop  = (wr_lane && {aw_addr_reg[7:2], 2'b00} == tcs_pkg::OFF_STOP) ? wbyte[1:0] : 2'b00;

  // ********
  // pin and priority outputs
  // ********
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      input_b_oe_o <= 1'b0;
      input_b_o    <= 1'b0;
    end else begin
      input_b_oe_o <= !port_dir_reg[tcs_pkg::INPUT_B_DIR_BIT];
      input_b_o    <= port_data_reg[tcs_pkg::INPUT_B_DIR_BIT];
    end
  end

  assign ch0_priority_o = {pri_msb_l_reg[tcs_pkg::PRI_LOW_BIT], pri_lsb_l_reg[tcs_pkg::PRI_LOW_BIT]};
  assign ch1_priority_o = {pri_msb_h_reg[tcs_pkg::PRI_HIGH_BIT], pri_lsb_h_reg[tcs_pkg::PRI_HIGH_BIT]};

  // ********
  // clock gate and prescaler
  // ********
  assign unit_on = clk_gate_reg[tcs_pkg::CLOCK_ON_BIT];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !unit_on) begin
      pre_cnt_reg <= 15'h0000;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 15'h0001;
    end
  end

  function automatic logic prs_tick(input logic [3:0] code, input logic [14:0] cnt);
    logic [15:0] mask;
    mask     = 16'(({1'b0, 15'h0001} << code) - 16'h0001);
    prs_tick = ((cnt & mask[14:0]) == mask[14:0]);
    return prs_tick;
  endfunction

  assign tick_zero = unit_on && prs_tick(prescale_reg[3:0], pre_cnt_reg);
  assign tick_one  = unit_on && prs_tick(prescale_reg[tcs_pkg::PRS_ONE_LSB +: 4], pre_cnt_reg);

  // ********
  // pin edges
  // ********
  assign pin_now = {input_b_i, timer_input_pin_i};

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_prev_reg <= 2'b00;
    end else begin
      pin_prev_reg <= pin_now;
    end
  end

  // ********
  // channels
  // ********
  for (genvar i = 0; i < 2; i++) begin : g_chan
    assign chan_link[i].mode_high  = mode_reg[i];
    assign chan_link[i].unit_on    = unit_on;
    assign chan_link[i].tick_zero  = tick_zero;
    assign chan_link[i].tick_one   = tick_one;
    assign chan_link[i].pin_rise   = pin_now[i] && !pin_prev_reg[i];
    assign chan_link[i].pin_fall   = !pin_now[i] && pin_prev_reg[i];
    assign chan_link[i].master_irq = (i == 1) ? irq_pulse[0] : 1'b0;
    assign chan_link[i].sw_start   = sw_start[i];
    assign chan_link[i].sw_stop    = sw_stop[i];
    assign run_flags[i]            = chan_link[i].run_flag;
    assign irq_pulse[i]            = chan_link[i].irq;
    assign capt[i]                 = chan_link[i].capture;

    tcs_channel #(
      .HAS_SPLIT (i == 1)
    ) u_chan (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .ch        (chan_link[i])
    );
  end

  assign channel_irq_o = irq_pulse;

  // ********
  // sticky interrupt pending flags, write 1 clears, set wins
  // ********
  always_comb begin
    irq_pend_next = irq_pend_reg;
    if (wr_lane && {aw_addr_reg[7:2], 2'b00} == tcs_pkg::OFF_IRQ_PEND) begin
      irq_pend_next = irq_pend_reg & ~wbyte[1:0];
    end
    irq_pend_next = irq_pend_next | irq_pulse;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_pend_reg <= 2'b00;
    end else begin
      irq_pend_reg <= irq_pend_next;
    end
  end

  // ********
  // axi4-lite read channel
  // ********
  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    case ({s_axi_araddr_i[7:2], 2'b00})
      tcs_pkg::OFF_PORT_DIR:  rd_data[7:0] = port_dir_reg;
      tcs_pkg::OFF_PORT_DATA: rd_data[7:0] = port_data_reg;
      tcs_pkg::OFF_CLK_GATE:  rd_data[7:0] = clk_gate_reg;
      tcs_pkg::OFF_PRI_LSB_L: rd_data[7:0] = pri_lsb_l_reg;
      tcs_pkg::OFF_PRI_MSB_L: rd_data[7:0] = pri_msb_l_reg;
      tcs_pkg::OFF_PRI_LSB_H: rd_data[7:0] = pri_lsb_h_reg;
      tcs_pkg::OFF_PRI_MSB_H: rd_data[7:0] = pri_msb_h_reg;
      tcs_pkg::OFF_START:     rd_data[7:0] = 8'h00;
      tcs_pkg::OFF_STOP:      rd_data[7:0] = 8'h00;
      tcs_pkg::OFF_PRESCALE:  rd_data[7:0] = prescale_reg;
      tcs_pkg::OFF_MODE_CH0:  rd_data[7:0] = mode_reg[0];
      tcs_pkg::OFF_MODE_CH1:  rd_data[7:0] = mode_reg[1];
      tcs_pkg::OFF_STATUS:    rd_data[7:0] = {6'h00, run_flags};
      tcs_pkg::OFF_IRQ_PEND:  rd_data[7:0] = {6'h00, irq_pend_reg};
      tcs_pkg::OFF_CAPT_CH0:  rd_data[15:0] = capt[0];
      tcs_pkg::OFF_CAPT_CH1:  rd_data[15:0] = capt[1];
      default:                rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= tcs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= rd_data;
      s_axi_rresp_o  <= rd_hit ? tcs_pkg::RESP_OKAY : tcs_pkg::RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end
endmodule

/* File: bench/tcs_timer_setup_properties.sv */
// tcs_props: port assertions of the timer setup block
`timescale 1ns/1ps
module tcs_props (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  // register bus
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic [7:0]  s_axi_awaddr_i,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  // pins
  input wire logic        input_b_oe_o,
  input wire logic [1:0]  channel_irq_o,
  input wire logic [1:0]  ch0_priority_o,
  input wire logic [1:0]  ch1_priority_o
);
  // ********
  // handshake sequences and checks
  // ********
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  reset_pri_a: assert property (
    $fell(rst_i) |-> ch0_priority_o == 2'b11 && ch1_priority_o == 2'b11) else $error("priority not lowest");
  pri_follow_a: assert property (
    $changed({ch0_priority_o, ch1_priority_o}) |-> s_axi_bvalid_o || $past(s_axi_bvalid_o)) else $error("priority moved");
  dir_follow_a: assert property (
    $changed(input_b_oe_o) |-> s_axi_bvalid_o || $past(s_axi_bvalid_o)) else $error("direction moved");
  wr_answer_a: assert property (
    wr_take |=> ##1 s_axi_bvalid_o) else $error("no write response");
  bresp_map_a: assert property (
    wr_take |=> ##1 s_axi_bresp_o == (($past(s_axi_awaddr_i, 2) > tcs_pkg::OFF_CAPT_CH1) ? 2'h2 : 2'h0))
    else $error("wrong write response");
  wr_hold_a: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("response dropped");
  rd_answer_a: assert property (
    rd_take |=> s_axi_rvalid_o) else $error("no read data");
  rd_hold_a: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
  bus_refuse_a: assert property (
    (!s_axi_bvalid_o || !s_axi_awready_o) && (!s_axi_rvalid_o || !s_axi_arready_o)) else $error("ready while busy");
  irq_pulse_a: assert property (
    |channel_irq_o |=> (channel_irq_o & $past(channel_irq_o)) == 2'b00) else $error("irq longer than a cycle");
endmodule
bind tcs_timer_setup tcs_props u_props (.*);

/* File: bench/tcs_pin_source.sv */
// tcs_pin_source: two-phase signal source on the timer input pins
`timescale 1ns/1ps
module tcs_pin_source (
  // clock and control
  input  wire logic       sys_clk_i,
  input  wire logic       en_i,
  input  wire logic [7:0] quarter_i,
  // two-phase pins
  output logic            pin_a_o,
  output logic            pin_b_o
);
  // ********
  // phase stepping, levels hold while stopped
  // ********
  logic [7:0] cnt_reg = 8'h00;
  logic [1:0] ph_reg = 2'h0;
  always @(posedge sys_clk_i) begin
    if (en_i) begin
      cnt_reg <= (cnt_reg >= quarter_i) ? 8'h00 : cnt_reg + 8'h01;
      if (cnt_reg >= quarter_i) ph_reg <= ph_reg + 2'h1;
    end
  end
  assign pin_a_o = ph_reg[1];
  assign pin_b_o = ph_reg[1] ^ ph_reg[0];
endmodule

/* File: bench/tcs_timer_setup_test.sv */
// tcs_timer_setup_test: self-checking bench of the timer setup block
`timescale 1ns/1ps
module tcs_timer_setup_test;
  // ********
  // stimulus, expectations and tables
  // ********
  logic             clk, rst, awv, wv, bre, arv, rre, en;
  logic [7:0]       awa, ara, q;
  logic [31:0]      wd, got, c0;
  logic [31:0]      seed = 32'h7CC6EC17;
  logic [3:0]       strb;
  logic [34:0]      e;
  logic [1:0]       exp_b[$];
  logic [34:0]      exp_r[$];
  wire logic        awr, wrd, bv, arr, rv, bo, boe, pa, pb, pbw;
  wire logic [1:0]  br, rr, irq, p0, p1;
  wire logic [31:0] rdat;
  int               fail_count, compares, cyc, n0, n1;
  logic [15:0]      rt[11] = '{16'h00FF, 16'h0800, 16'h0CFF, 16'h10FF, 16'h14FF, 16'h18FF, 16'h2000,
                               16'h2400, 16'h2800, 16'h2C00, 16'h3000};
  logic [23:0]      ts[7] = '{24'h1C0000, 24'h1C0101, 24'h200001, 24'h200100, 24'h1C0303, 24'h200201, 24'h1C0001};
  logic [7:0]       cd[5] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h06};
  tcs_timer_setup DUT (
    .sys_clk_i(clk), .rst_i(rst), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
    .s_axi_awprot_i(3'h0), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_wdata_i(wd), .s_axi_wstrb_i(strb),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_bresp_o(br), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_araddr_i(ara), .s_axi_arprot_i(3'h0), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .s_axi_rdata_o(rdat),
    .s_axi_rresp_o(rr), .timer_input_pin_i(pa), .input_b_i(pbw), .input_b_o(bo), .input_b_oe_o(boe),
    .channel_irq_o(irq), .ch0_priority_o(p0), .ch1_priority_o(p1));
  tcs_pin_source SRC (.sys_clk_i(clk), .en_i(en), .quarter_i(q), .pin_a_o(pa), .pin_b_o(pb));
  assign pbw = boe ? bo : pb;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [33:0] g, input logic [33:0] x, input string m);
    compares++;
    if (g !== x) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    exp_b.push_back(r);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      ad = ad | awr;
      dd = dd | wrd;
      awv <= !ad;
      wv <= !dd;
    end
    do @(posedge clk); while (bv !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0, input logic c = 1'b1);
    exp_r.push_back({c, r, 24'h0, d});
    ara <= a;
    arv <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    got = rdat;
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ********
  // clock, response monitor, irq counters, timeout
  // ********
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk) begin
    n0 += (irq[0] === 1'b1);
    n1 += (irq[1] === 1'b1);
  end
  always @(posedge clk) begin
    cyc++;
    if (bv === 1'b1 && bre === 1'b1) chk(br, exp_b.pop_front(), "write response");
    if (rv === 1'b1 && rre === 1'b1) begin
      e = exp_r.pop_front();
      chk({rr, rdat & {32{e[34]}}}, {e[33:32], e[31:0] & {32{e[34]}}}, "read data");
    end
    if (cyc == 20000) begin
      fail_count++;
      $display("[ERR] %0t timeout", $time);
      conclude();
    end
  end
  // ********
  // main sequence
  // ********
  initial begin
    {rst, awv, wv, bre, arv, rre, en} = 7'h4A;
    {awa, ara, wd, strb, q} = {48'h0, 4'h1, 8'h07};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rt[i]) rd(rt[i][15:8], rt[i][7:0]);
    rd(8'h40, 8'h00, 2'h2);
    wr(8'h40, 8'h00, 2'h2);
    $display("reset values done");
    wr(tcs_pkg::OFF_PORT_DATA, 8'h10);
    wr(tcs_pkg::OFF_PORT_DIR, 8'hEF);
    repeat (3) @(posedge clk);
    chk({boe, bo}, 2'b11, "input b drive");
    wr(tcs_pkg::OFF_PORT_DIR, 8'hFF);
    repeat (3) @(posedge clk);
    chk(boe, 1'b0, "input b release");
    for (int k = 0; k < 4; k++) begin
      wr(tcs_pkg::OFF_PRI_MSB_L, {k[1], 7'h0});
      wr(tcs_pkg::OFF_PRI_LSB_L, {k[0], 7'h0});
      wr(tcs_pkg::OFF_PRI_MSB_H, {7'h0, ~k[1]});
      wr(tcs_pkg::OFF_PRI_LSB_H, {7'h0, ~k[0]});
      repeat (3) @(posedge clk);
      chk({p0, p1}, {k[1:0], ~k[1:0]}, "priority code");
    end
    $display("direction and priority done");
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      wr(tcs_pkg::OFF_PRESCALE, seed[7:0]);
      rd(tcs_pkg::OFF_PRESCALE, seed[7:0]);
      wr(tcs_pkg::OFF_MODE_CH0, (seed[15:8] & 8'h98) | cd[i]);
      rd(tcs_pkg::OFF_MODE_CH0, (seed[15:8] & 8'h90) | cd[i]);
      wr(tcs_pkg::OFF_MODE_CH1, (seed[23:16] & 8'h98) | cd[i]);
      rd(tcs_pkg::OFF_MODE_CH1, (seed[23:16] & 8'h98) | cd[i]);
    end
    strb <= 4'h0;
    wr(tcs_pkg::OFF_PRESCALE, ~seed[7:0]);
    strb <= 4'h1;
    rd(tcs_pkg::OFF_PRESCALE, seed[7:0]);
    wr(tcs_pkg::OFF_PRESCALE, 8'h00);
    wr(tcs_pkg::OFF_MODE_CH0, 8'h00);
    wr(tcs_pkg::OFF_MODE_CH1, 8'h00);
    wr(tcs_pkg::OFF_CLK_GATE, 8'h01);
    $display("mode fields done");
    foreach (ts[i]) begin
      wr(ts[i][23:16], ts[i][15:8]);
      rd(tcs_pkg::OFF_STATUS, ts[i][7:0]);
    end
    en <= 1'b1;
    repeat (100) @(posedge clk);
    chk(n0, 0, "pin started channel");
    wr(tcs_pkg::OFF_MODE_CH0, 8'h01);
    repeat (200) @(posedge clk);
    chk(n0 > 2, 1'b1, "no edge capture");
    en <= 1'b0;
    repeat (4) @(posedge clk);
    rd(tcs_pkg::OFF_IRQ_PEND, 8'h01);
    wr(tcs_pkg::OFF_IRQ_PEND, 8'h01);
    rd(tcs_pkg::OFF_IRQ_PEND, 8'h00);
    en <= 1'b1;
    repeat (100) @(posedge clk);
    rd(tcs_pkg::OFF_CAPT_CH0, 8'h00, 2'h0, 1'b0);
    c0 = got;
    wr(tcs_pkg::OFF_PRESCALE, 8'h03);
    repeat (120) @(posedge clk);
    rd(tcs_pkg::OFF_CAPT_CH0, 8'h00, 2'h0, 1'b0);
    chk(c0 + 8 - 8 * got <= 16, 1'b1, "prescale ratio");
    $display("start stop and capture done");
    wr(tcs_pkg::OFF_CLK_GATE, 8'h00);
    n0 = 0;
    repeat (100) @(posedge clk);
    chk(n0, 0, "gated unit ran");
    wr(tcs_pkg::OFF_CLK_GATE, 8'h01);
    wr(tcs_pkg::OFF_PRESCALE, 8'h00);
    wr(tcs_pkg::OFF_MODE_CH0, 8'h02);
    wr(tcs_pkg::OFF_START, 8'h01);
    n0 = 0;
    repeat (100) @(posedge clk);
    chk(n0 > 0, 1'b1, "both edge capture");
    wr(tcs_pkg::OFF_MODE_CH0, 8'h01);
    wr(tcs_pkg::OFF_MODE_CH1, 8'h06);
    wr(tcs_pkg::OFF_START, 8'h03);
    n1 = 0;
    repeat (200) @(posedge clk);
    chk(n1 > 0, 1'b1, "slave end event");
    $display("gate and trigger sources done");
    conclude();
  end
endmodule
